// ---- rtd_tick_divider.sv ----
// Purpose: Fractional divider making the 100 Hz tick and reset for the RTC
// Assumes: CORE_CLK is the divider source clock, Avalon-MM slave
// Notes: One control register, waitrequest high for one cycle on reads, low on writes
//
// How it works
// [R1] The tick toward the RTC comes only in the cycle after one in which the enable bit is one.
// [R2] The RTC reset output follows the reset request bit while it is one.
// [R3] The base select bit picks a window of 1000 (zero) or 1024 (one) periods.
// [R4] The integer divisor lives in bits 18:10 and resets to 0x147.
// [R5] With base 1024, frac periods of each 1024 divide by int+1, the rest by int.
// [R6] With base 1000, frac periods of each 1000 divide by int+1, the rest by int; a frac of 1000 or more makes every period long.
// [R7] Long periods are spread by an accumulator which restarts on enable.
//
// Local design decision: register access over Avalon-MM.
`timescale 1ns/1ps
module rtd_tick_divider (
    input wire logic CORE_CLK,
    input wire logic RST_B,
    input wire logic [31:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    output logic RTC_TICK,
    output logic RTC_RESET
);
    import rtd_pkg::*;
    typedef struct packed {
        logic rst_req;
        logic enable;
        logic base_sel;
        logic [8:0] div_int;
        logic [9:0] frac;
        logic en_d;
        logic tick;
        logic [10:0] gap;
        logic [31:0] rdata;
    } rtd_top_s;
    rtd_top_s st_reg;
    rtd_top_s st_next;
    logic hit;
    logic [31:0] ctrl_word;
    logic [31:0] wmask;
    logic [31:0] new_word;
    logic period_end;
    logic long_period;
    logic restart;
    logic [9:0] divisor;

    assign hit = (AVS_ADDRESS[15:0] == RTD_CTRL_ADDR_LO);
    assign restart = st_reg.enable & ~st_reg.en_d;
    // Divisor follows long_period, which changes the cycle after a period closes, and follows div_int writes at once
    assign divisor = long_period ? ({1'b0, st_reg.div_int} + 10'h001) : {1'b0, st_reg.div_int}; // [R5] [R6]

    rtd_period_counter u_cnt (
        .CORE_CLK(CORE_CLK),
        .RST_B(RST_B),
        .run(st_reg.enable & ~restart),
        .divisor(divisor),
        .period_end(period_end)
    );

    rtd_frac_accum u_acc (
        .CORE_CLK(CORE_CLK),
        .RST_B(RST_B),
        .restart(restart),
        .step(period_end),
        .base_sel(st_reg.base_sel),
        .frac(st_reg.frac),
        .long_period(long_period)
    );

    always_comb begin
        st_next = st_reg;
        ctrl_word = 32'h00000000;
        ctrl_word[RTD_RST_REQ_BIT] = st_reg.rst_req;
        ctrl_word[RTD_ENABLE_BIT] = st_reg.enable;
        ctrl_word[RTD_BASE_SEL_BIT] = st_reg.base_sel;
        ctrl_word[RTD_INT_MSB:RTD_INT_LSB] = st_reg.div_int;
        ctrl_word[RTD_FRAC_MSB:RTD_FRAC_LSB] = st_reg.frac;
        wmask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}}, {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
        new_word = (ctrl_word & ~wmask) | (AVS_WRITEDATA & wmask);
        st_next.en_d = st_reg.enable;
        st_next.tick = st_reg.enable & period_end; // [R1]
        // Cycles since the last tick, saturating; only the checks read it
        if (st_reg.tick || !st_reg.enable) begin
            st_next.gap = 11'h000;
        end else if (st_reg.gap != 11'h7FF) begin
            st_next.gap = st_reg.gap + 11'h001;
        end
        if (AVS_WRITE && hit) begin
            st_next.rst_req = new_word[RTD_RST_REQ_BIT]; // [R2]
            st_next.enable = new_word[RTD_ENABLE_BIT];
            st_next.base_sel = new_word[RTD_BASE_SEL_BIT]; // [R3]
            st_next.div_int = new_word[RTD_INT_MSB:RTD_INT_LSB]; // [R4]
            st_next.frac = new_word[RTD_FRAC_MSB:RTD_FRAC_LSB];
        end
        // Read data registered; unmapped reads return zero
        if (AVS_READ) begin
            st_next.rdata = hit ? ctrl_word : RTD_UNMAPPED_DATA;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            st_reg <= '0;
            st_reg.div_int <= RTD_INT_RESET; // [R4]
            st_reg.frac <= RTD_FRAC_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // Read answers a cycle later; write needs no wait
    logic rd_pend_reg;
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            rd_pend_reg <= 1'b0;
        end else begin
            rd_pend_reg <= AVS_READ & ~rd_pend_reg;
        end
    end
    assign AVS_WAITREQUEST = AVS_READ & ~rd_pend_reg;
    assign AVS_READDATA = st_reg.rdata;
    assign RTC_TICK = st_reg.tick;
    assign RTC_RESET = st_reg.rst_req;

    a_tick_needs_enable: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R1]
        RTC_TICK |-> $past(st_reg.enable))
        else $error("tick while divider disabled");
    a_reset_follows_req: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R2]
        (AVS_WRITE && hit && AVS_BYTEENABLE[2]) |=> (RTC_RESET == $past(AVS_WRITEDATA[RTD_RST_REQ_BIT])))
        else $error("rtc reset not following request bit");
    a_int_field_write: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R4]
        (AVS_WRITE && hit && (&AVS_BYTEENABLE)) |=> (st_reg.div_int == $past(AVS_WRITEDATA[18:10])))
        else $error("integer divisor not stored");
    a_base_sel_store: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R3]
        (AVS_WRITE && hit && AVS_BYTEENABLE[2]) |=> (st_reg.base_sel == $past(AVS_WRITEDATA[19])))
        else $error("base select not stored");
    a_short_period: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R5]
        (st_reg.enable && !long_period) |-> (divisor == {1'b0, st_reg.div_int}))
        else $error("short period divisor wrong");
    a_long_period: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R6]
        (st_reg.enable && long_period) |-> (divisor == {1'b0, st_reg.div_int} + 10'h001))
        else $error("long period divisor wrong");
    a_no_tick_idle: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R1]
        (!st_reg.enable [*3]) |-> !RTC_TICK)
        else $error("tick after disable");
    a_restart_clears: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R7]
        restart |=> !long_period)
        else $error("window not restarted on enable");
    a_read_one_wait: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        (AVS_READ && !rd_pend_reg) |-> AVS_WAITREQUEST ##1 (!AVS_WAITREQUEST || !AVS_READ))
        else $error("read wait not one cycle");

    // Control fields by write and by byte lane
    a_enable_store: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R1]
        (AVS_WRITE && hit && AVS_BYTEENABLE[2]) |=> (st_reg.enable == $past(AVS_WRITEDATA[20])))
        else $error("enable bit not stored");

    a_enable_hold: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R1]
        !(AVS_WRITE && hit) |=> $stable(st_reg.enable))
        else $error("enable changed without write");

    a_enable_lane: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R1]
        (AVS_WRITE && hit && !AVS_BYTEENABLE[2]) |=> $stable(st_reg.enable))
        else $error("enable changed by other lane");

    a_reset_hold: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R2]
        !(AVS_WRITE && hit) |=> $stable(RTC_RESET))
        else $error("rtc reset changed without write");

    a_reset_lane: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R2]
        (AVS_WRITE && hit && !AVS_BYTEENABLE[2]) |=> $stable(RTC_RESET))
        else $error("rtc reset changed by other lane");

    a_base_hold: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R3]
        !(AVS_WRITE && hit) |=> $stable(st_reg.base_sel))
        else $error("base select changed without write");

    a_base_lane: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R3]
        (AVS_WRITE && hit && !AVS_BYTEENABLE[2]) |=> $stable(st_reg.base_sel))
        else $error("base select changed by other lane");

    a_int_hold: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R4]
        !(AVS_WRITE && hit) |=> $stable(st_reg.div_int))
        else $error("integer divisor changed without write");

    a_int_upper_lane: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R4]
        (AVS_WRITE && hit && AVS_BYTEENABLE == 4'h4) |=>
        ((st_reg.div_int[5:0] == $past(st_reg.div_int[5:0])) && (st_reg.div_int[8:6] == $past(AVS_WRITEDATA[18:16]))))
        else $error("integer divisor lane merge wrong");

    a_int_lower_lane: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R4]
        (AVS_WRITE && hit && AVS_BYTEENABLE == 4'h2) |=>
        ((st_reg.div_int[8:6] == $past(st_reg.div_int[8:6])) && (st_reg.div_int[5:0] == $past(AVS_WRITEDATA[15:10]))))
        else $error("integer divisor low lane wrong");

    a_frac_store: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R5]
        (AVS_WRITE && hit && (&AVS_BYTEENABLE)) |=> (st_reg.frac == $past(AVS_WRITEDATA[9:0])))
        else $error("fraction not stored");

    a_frac_hold: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R6]
        !(AVS_WRITE && hit) |=> $stable(st_reg.frac))
        else $error("fraction changed without write");

    a_frac_low_lane: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R6]
        (AVS_WRITE && hit && AVS_BYTEENABLE == 4'h1) |=>
        ((st_reg.frac[9:8] == $past(st_reg.frac[9:8])) && (st_reg.frac[7:0] == $past(AVS_WRITEDATA[7:0]))))
        else $error("fraction low lane wrong");

    a_top_lane_ignored: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        (AVS_WRITE && hit && AVS_BYTEENABLE == 4'h8) |=> (ctrl_word == $past(ctrl_word)))
        else $error("unused lane changed control");

    a_unmapped_write: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        (AVS_WRITE && !hit) |=> (ctrl_word == $past(ctrl_word)))
        else $error("unmapped write changed control");

    // Tick timing
    a_tick_from_period: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R1]
        RTC_TICK |-> $past(period_end))
        else $error("tick without period end");

    a_tick_off_disabled: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R1]
        !st_reg.enable |=> !RTC_TICK)
        else $error("tick one cycle after disable");

    a_divisor_range: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R5]
        st_reg.enable |-> (divisor <= 10'h200))
        else $error("divisor above int plus one");

    // Longest period is 512 cycles plus the enable latency
    a_gap_bounded: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R5] [R6]
        st_reg.enable |-> (st_reg.gap <= 11'h208))
        else $error("tick period too long");

    a_restart_on_rise: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R7]
        $rose(st_reg.enable) |-> restart)
        else $error("no restart on enable");

    a_restart_single: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R7]
        restart |=> !restart)
        else $error("restart longer than one cycle");

    a_restart_quiet: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R7]
        restart |=> (!RTC_TICK [*2]))
        else $error("tick right after restart");

    // Register bus timing and read data
    a_write_no_wait: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        (AVS_WRITE && !AVS_READ) |-> !AVS_WAITREQUEST)
        else $error("write stalled");

    a_idle_no_wait: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        !AVS_READ |-> !AVS_WAITREQUEST)
        else $error("waitrequest without read");

    a_pend_clears: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        rd_pend_reg |=> !rd_pend_reg)
        else $error("read pending stuck");

    a_read_high_zero: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        (AVS_READ && hit) |=> (AVS_READDATA[31:22] == 10'h000))
        else $error("unused read bits not zero");

    a_read_ctrl_value: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        (AVS_READ && hit) |=> (AVS_READDATA == $past(ctrl_word)))
        else $error("read data not control word");

    a_unmapped_read: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        (AVS_READ && !hit) |=> (AVS_READDATA == RTD_UNMAPPED_DATA))
        else $error("unmapped read not zero");

    a_rdata_hold: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        !AVS_READ |=> $stable(AVS_READDATA))
        else $error("read data changed without read");
endmodule : rtd_tick_divider

// ---- rtd_pkg.sv ----
// Purpose: Shared constants for the RTC tick fractional divider
// Assumes: Avalon-MM register access, 32-bit data, one clock
// Notes: Offset is the printed byte address, low 16 bits decoded
package rtd_pkg;
    localparam logic [31:0] RTD_CTRL_OFFSET = 32'h5000424C;
    localparam logic [15:0] RTD_CTRL_ADDR_LO = 16'h424C;
    localparam int RTD_RST_REQ_BIT = 21;
    localparam int RTD_ENABLE_BIT = 20;
    localparam int RTD_BASE_SEL_BIT = 19;
    localparam int RTD_INT_MSB = 18;
    localparam int RTD_INT_LSB = 10;
    localparam int RTD_FRAC_MSB = 9;
    localparam int RTD_FRAC_LSB = 0;
    localparam logic [8:0] RTD_INT_RESET = 9'h147;
    localparam logic [9:0] RTD_FRAC_RESET = 10'h2A8;
    localparam logic [10:0] RTD_BASE_1000 = 11'h3E8;
    localparam logic [10:0] RTD_BASE_1024 = 11'h400;
    localparam logic [31:0] RTD_UNMAPPED_DATA = 32'h00000000;
endpackage : rtd_pkg

// ---- rtd_frac_accum.sv ----
// Purpose: Fractional accumulator choosing long or short periods
// Assumes: Step taken once per finished tick period
// Notes: Bresenham style, spreads long periods evenly
`timescale 1ns/1ps
module rtd_frac_accum (
    input wire logic CORE_CLK,
    input wire logic RST_B,
    input wire logic restart,
    input wire logic step,
    input wire logic base_sel,
    input wire logic [9:0] frac,
    output logic long_period
);
    import rtd_pkg::*;
    typedef struct packed {
        logic [10:0] acc;
        logic lng;
    } rtd_acc_s;
    rtd_acc_s st_reg;
    rtd_acc_s st_next;
    logic [10:0] base;
    logic [11:0] sum;
    always_comb begin
        st_next = st_reg;
        base = base_sel ? RTD_BASE_1024 : RTD_BASE_1000; // [R3]
        sum = {1'b0, st_reg.acc} + {2'b00, frac};
        if (restart) begin
            st_next.acc = 11'h000; // [R7]
            st_next.lng = 1'b0;
        end else if (step) begin
            // Frac at or above base means every period is long
            if (sum >= {1'b0, base}) begin // [R5] [R6]
                st_next.acc = 11'(sum - {1'b0, base});
                st_next.lng = 1'b1;
            end else begin
                st_next.acc = sum[10:0];
                st_next.lng = 1'b0;
            end
        end
    end
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
    assign long_period = st_reg.lng;
endmodule : rtd_frac_accum

// ---- rtd_period_counter.sv ----
// Purpose: Counts one tick period and pulses at its end
// Assumes: Divisor compared every cycle, not latched at period start
// Notes: Divisor of zero is treated as one
`timescale 1ns/1ps
module rtd_period_counter (
    input wire logic CORE_CLK,
    input wire logic RST_B,
    input wire logic run,
    input wire logic [9:0] divisor,
    output logic period_end
);
    import rtd_pkg::*;
    typedef struct packed {
        logic [9:0] cnt;
        logic pend;
    } rtd_cnt_s;
    rtd_cnt_s st_reg;
    rtd_cnt_s st_next;
    always_comb begin
        st_next = st_reg;
        st_next.pend = 1'b0;
        if (!run) begin
            st_next.cnt = 10'h000;
        end else if (st_reg.cnt + 10'h001 >= divisor) begin
            st_next.cnt = 10'h000;
            st_next.pend = 1'b1;
        end else begin
            st_next.cnt = st_reg.cnt + 10'h001;
        end
    end
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
    assign period_end = st_reg.pend;
endmodule : rtd_period_counter

// ---- rtd_rtc_model.sv ----
// Purpose: Behavioural RTC counter consuming the divider tick
// Assumes: Tick is a one-cycle pulse on the divider clock
// Notes: Records every tick period length in cycles for the bench
`timescale 1ns/1ps
module rtd_rtc_model (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic tick,
    input wire logic rtc_reset
);
    int gap;
    int ticks;
    int per_q[$];
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            gap = 0;
            ticks = 0;
        end else begin
            gap++;
            if (tick === 1'b1) begin
                per_q.push_back(gap);
                gap = 0;
                ticks++;
            end
            // Held reset keeps the counter cleared
            if (rtc_reset === 1'b1) begin
                ticks = 0;
            end
        end
    end
endmodule : rtd_rtc_model

// ---- rtd_tick_divider_tb_top.sv ----
// Purpose: Self-checking bench for the RTC tick fractional divider
// Assumes: Avalon-MM master, partner RTC model records periods
// Notes: Small random divisors keep a full window short
`timescale 1ns/1ps
module rtd_tick_divider_tb_top;
    import rtd_pkg::*;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic av_rd = 1'b0;
    logic av_wr = 1'b0;
    logic [31:0] av_addr = '0;
    logic [31:0] av_wd = '0;
    logic [31:0] av_rdata;
    logic av_wait;
    logic tick;
    logic rtc_rst;
    logic [31:0] rd;
    int err_total = 0;
    int cmp_count = 0;
    int seed, div, frac, base, longs, n;
    rtd_tick_divider DUT (.CORE_CLK(core_clk), .RST_B(rst_b), .AVS_ADDRESS(av_addr), .AVS_READ(av_rd),
        .AVS_WRITE(av_wr), .AVS_WRITEDATA(av_wd), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(av_rdata),
        .AVS_WAITREQUEST(av_wait), .RTC_TICK(tick), .RTC_RESET(rtc_rst));
    rtd_rtc_model m (.core_clk(core_clk), .rst_b(rst_b), .tick(tick), .rtc_reset(rtc_rst));
    initial begin
        forever #2.5 core_clk = ~core_clk;
    end
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge core_clk);
        av_rd <= ~wr;
        av_wr <= wr;
        av_addr <= a;
        av_wd <= d;
        // Answer time is the slave's business; only the watchdog ends a wait
        // Looked at mid-cycle, where waitrequest and readdata stand still
        do @(negedge core_clk); while (av_wait !== 1'b0);
        rd = av_rdata;
        @(posedge core_clk);
        av_rd <= 1'b0;
        av_wr <= 1'b0;
    endtask : bus
    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : chk
    task complete_run;
        $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : complete_run
    initial begin
        repeat (60000) @(posedge core_clk);
        err_total++;
        complete_run();
    end
    initial begin
        seed = $urandom(66);
        repeat (10) @(posedge core_clk);
        rst_b <= 1'b1;
        bus(1'b0, RTD_CTRL_OFFSET, 32'h0);
        chk(32'h00051EA8, rd);
        bus(1'b1, 32'h50004250, 32'hFFFFFFFF);
        bus(1'b0, 32'h50004250, 32'h0);
        chk(32'h0, rd);
        bus(1'b0, RTD_CTRL_OFFSET, 32'h0);
        chk(32'h00051EA8, rd);
        repeat (400) @(posedge core_clk);
        chk(32'h0, m.ticks);
        bus(1'b1, RTD_CTRL_OFFSET, 32'h00200000);
        repeat (2) @(posedge core_clk);
        chk(32'h1, {31'h0, rtc_rst});
        for (int i = 0; i < 3; i++) begin
            div = 2 + ($urandom % 4);
            base = (i & 1) ? 1024 : 1000;
            frac = (i == 2) ? 0 : ($urandom % base);
            bus(1'b1, RTD_CTRL_OFFSET, (i & 1) << 19 | div << 10 | frac);
            repeat (2) @(posedge core_clk);
            chk(32'h0, {31'h0, rtc_rst});
            m.per_q.delete();
            bus(1'b1, RTD_CTRL_OFFSET, 1 << 20 | (i & 1) << 19 | div << 10 | frac);
            while (m.per_q.size() < base + 2) @(posedge core_clk);
            longs = 0;
            // First period includes enable latency, so the window starts one later
            for (int k = 1; k <= base; k++) begin
                if (m.per_q[k] == div + 1) longs++;
                else chk(div, m.per_q[k]);
            end
            chk(frac, longs);
        end
        bus(1'b1, RTD_CTRL_OFFSET, div << 10);
        repeat (3) @(posedge core_clk);
        n = m.ticks;
        repeat (60) @(posedge core_clk);
        chk(n, m.ticks);
        complete_run();
    end
endmodule : rtd_tick_divider_tb_top
